// ---- lpc_pixel_clock_gen.sv ----
// pixel clock generator: serial programming port, control bits, apb view,
// reference and feedback dividers, gated and re-phased pixel divider
// assumes all pins synchronous to pclk; pclk runs at twice the vco rate
//
// Notes on behaviour
// - pixel modulus 3,4,5,6,8,10,12,16,20 only
// - pixel output duty exactly half
// - pixel divider clocked from post-scaler
// - gate assertion restarts phase, polarity selectable
// - gate off: finish cycle, hold high
// - restart resolved to a post-scaler tick, half a vco cycle at pass
// - restart delay is K vco periods
// - post-scaler ignores the gate input
// - scaler: pass, halve, quarter, test
// - reference modulus 1 to 128
// - feedback modulus 37 to 392
// - double bit doubles feedback modulus
// - vco equals reference times ratio
// - shift data on serial clock rise
// - hold sampled on same rising edge
// - hold low: shift only, no change
// - hold high: copy shift into control
// - gate polarity from control bit 39
// - output suppressed by control bit 46
// - four-bit modulus code table
// - reset gives divide by four, bypass
// - scaler select 00/01/10/11 meanings
// - bypass bit feeds reference, defaults one
`timescale 1ns/1ps
module lpc_pixel_clock_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_hold_in,
  input wire logic ref_osc_in,
  input wire logic pixel_gate_in,
  output logic pixel_clk_out,
  output logic ref_div_out,
  output logic fb_div_out
);
  typedef enum logic [1:0] {
    LPC_IDLE,
    LPC_DELAY,
    LPC_RUN
  } lpc_state_e;

  lpc_ps_if ps ();

  logic [55:0] ctrl_reg;
  logic [55:0] shift_reg;
  logic [5:0] bit_cnt_reg;
  logic sclk_q_reg;
  logic gate_q_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic out_reg;
  logic pix_reg;
  logic phase_low_reg;
  logic [4:0] delay_cnt_reg;
  logic [4:0] half_cnt_reg;
  lpc_state_e state_reg;
  lpc_state_e state_next;
  logic [6:0] ref_cnt_reg;
  logic [10:0] fb_cnt_reg;
  logic ref_q_reg;
  logic ref_div_reg;
  logic fb_div_reg;

  logic sclk_rise;
  logic [55:0] shift_next;
  logic [3:0] mod_code;
  logic [4:0] modulus;
  logic [4:0] k_half;
  logic gate_active;
  logic gate_assert;
  logic apb_access;
  logic apb_done;
  logic addr_ok;
  logic [8:0] fb_code;
  logic [8:0] fb_base;
  logic [9:0] fb_mod;
  logic ref_edge;

  ////////////////////////////////////////////////////////////////////////
  // control fields

  assign mod_code = ctrl_reg[lpc_pkg::POS_MOD +: 4];
  assign modulus = lpc_pkg::lpc_modulus(mod_code);
  assign k_half = lpc_pkg::lpc_k_half(mod_code);

  assign ps.bypass = ctrl_reg[lpc_pkg::POS_BYPASS];
  assign ps.ref_level = ref_osc_in;
  assign ps.scale = ctrl_reg[lpc_pkg::POS_SCALE +: 2];

  lpc_postscaler u_scaler (
    .pclk(pclk),
    .presetn(presetn),
    .ps(ps)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial programming port

  assign sclk_rise = serial_shift_clock & ~sclk_q_reg;
  // first bit ends at index 0
  assign shift_next = {serial_data_in, shift_reg[55:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q_reg <= 1'b0;
    end else begin
      sclk_q_reg <= serial_shift_clock;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= shift_next;
    end
  end

  // bits taken since the last transfer, for software to watch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= 6'h00;
    end else if (sclk_rise) begin
      bit_cnt_reg <= serial_hold_in ? 6'h00 : bit_cnt_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, registered answer

  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready_reg;
  assign addr_ok = (paddr == lpc_pkg::ADDR_CTRL_LO) |
                   (paddr == lpc_pkg::ADDR_CTRL_HI) |
                   (paddr == lpc_pkg::ADDR_STATUS) |
                   (paddr == lpc_pkg::ADDR_SHIFT_LO) |
                   (paddr == lpc_pkg::ADDR_SHIFT_HI);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_access & ~pready_reg;
      pslverr_reg <= apb_access & ~pready_reg & ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_access & ~pready_reg) begin
      prdata_reg <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          lpc_pkg::ADDR_CTRL_LO: prdata_reg <= ctrl_reg[31:0];
          lpc_pkg::ADDR_CTRL_HI: prdata_reg <= {8'h00, ctrl_reg[55:32]};
          lpc_pkg::ADDR_STATUS: prdata_reg <= {18'h00000, bit_cnt_reg,
            3'h0, phase_low_reg, state_reg, gate_active, out_reg};
          lpc_pkg::ADDR_SHIFT_LO: prdata_reg <= shift_reg[31:0];
          lpc_pkg::ADDR_SHIFT_HI: prdata_reg <= {8'h00, shift_reg[55:32]};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active control bits

  // serial transfer beats a same-cycle apb write: the pins are the
  // documented path, software loading is a convenience on top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= lpc_pkg::CTRL_RESET;
    end else if (sclk_rise & serial_hold_in) begin
      ctrl_reg <= shift_next;
    end else if (apb_done & pwrite) begin
      if (paddr == lpc_pkg::ADDR_CTRL_LO) begin
        ctrl_reg[31:0] <= pwdata;
      end else if (paddr == lpc_pkg::ADDR_CTRL_HI) begin
        ctrl_reg[55:32] <= pwdata[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate input

  assign gate_active = ctrl_reg[lpc_pkg::POS_POL] ? pixel_gate_in
                                                  : ~pixel_gate_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q_reg <= 1'b0;
    end else begin
      gate_q_reg <= gate_active;
    end
  end

  // relies on off gap
  // a gap shorter than a pixel period still restarts, but the cycle
  // cut short then is not a full one
  assign gate_assert = gate_active & ~gate_q_reg;

  ////////////////////////////////////////////////////////////////////////
  // pixel divider state

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LPC_IDLE: begin
        if (gate_assert) begin
          state_next = LPC_DELAY;
        end
      end
      LPC_DELAY: begin
        if (!gate_active) begin
          state_next = LPC_IDLE;
        // start on a post-scaler tick, else the first low phase runs short
        end else if (ps.div_half && delay_cnt_reg >= k_half - 5'h01) begin
          state_next = LPC_RUN;
        end
      end
      LPC_RUN: begin
        if (gate_assert) begin
          state_next = LPC_DELAY;
        end else if (ps.div_half && !phase_low_reg &&
                     half_cnt_reg == modulus - 5'h01 && !gate_active) begin
          state_next = LPC_IDLE;
        end
      end
      default: state_next = LPC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= LPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_cnt_reg <= 5'h00;
    end else if (state_reg != LPC_DELAY) begin
      delay_cnt_reg <= 5'h00;
    end else if (ps.vco_half) begin
      delay_cnt_reg <= delay_cnt_reg + 5'h01;
    end
  end

  // modulus halves per phase
  // each phase lasts modulus half-ticks, so odd moduli stay symmetric
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_reg <= 5'h00;
      phase_low_reg <= 1'b0;
    end else if (state_next != LPC_RUN || state_reg != LPC_RUN) begin
      half_cnt_reg <= 5'h00;
      phase_low_reg <= (state_next == LPC_RUN);
    end else if (ps.div_half) begin
      if (half_cnt_reg == modulus - 5'h01) begin
        half_cnt_reg <= 5'h00;
        phase_low_reg <= ~phase_low_reg;
      end else begin
        half_cnt_reg <= half_cnt_reg + 5'h01;
      end
    end
  end

  // idle holds level high
  // a cycle is low then high, so stopping at its end leaves it high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_reg <= 1'b1;
    end else begin
      pix_reg <= (state_next != LPC_RUN) | ~phase_low_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b1;
    end else if (ps.scale == 2'(lpc_pkg::LPC_SC_TEST)) begin
      out_reg <= ctrl_reg[lpc_pkg::POS_AUX];
    end else if (ctrl_reg[lpc_pkg::POS_SUPPRESS]) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= pix_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synthesizer dividers feeding the analog phase detector

  assign fb_code = ctrl_reg[lpc_pkg::POS_FBDIV +: 9];
  assign fb_base = (fb_code < lpc_pkg::FB_MIN) ? lpc_pkg::FB_MIN :
                   (fb_code > lpc_pkg::FB_MAX) ? lpc_pkg::FB_MAX : fb_code;
  assign fb_mod = ctrl_reg[lpc_pkg::POS_DOUBLE] ? {fb_base, 1'b0}
                                                : {1'b0, fb_base};

  assign ref_edge = ctrl_reg[lpc_pkg::POS_REFEDGE] ? (~ref_osc_in & ref_q_reg)
                                                   : (ref_osc_in & ~ref_q_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q_reg <= 1'b0;
    end else begin
      ref_q_reg <= ref_osc_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg <= 7'h00;
      ref_div_reg <= 1'b0;
    end else begin
      ref_div_reg <= 1'b0;
      if (ref_edge) begin
        if (ref_cnt_reg >= ctrl_reg[lpc_pkg::POS_REFDIV +: 7]) begin
          ref_cnt_reg <= 7'h00;
          ref_div_reg <= 1'b1;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + 7'h01;
        end
      end
    end
  end

  // one vco period is two vco halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_reg <= 11'h000;
      fb_div_reg <= 1'b0;
    end else begin
      fb_div_reg <= 1'b0;
      if (ps.vco_half) begin
        if (fb_cnt_reg >= {fb_mod, 1'b0} - 11'h001) begin
          fb_cnt_reg <= 11'h000;
          fb_div_reg <= 1'b1;
        end else begin
          fb_cnt_reg <= fb_cnt_reg + 11'h001;
        end
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pixel_clk_out = out_reg;
  assign ref_div_out = ref_div_reg;
  assign fb_div_out = fb_div_reg;
endmodule

// ---- lpc_pkg.sv ----
// constants shared by the pixel clock generator files
// assumes pclk stands in for twice the vco rate (one pclk = half vco)
package lpc_pkg;
  localparam int unsigned CTRL_W = 56;
  localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
  localparam logic [7:0] ADDR_CTRL_HI = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SHIFT_LO = 8'h0c;
  localparam logic [7:0] ADDR_SHIFT_HI = 8'h10;
  // field positions: control bit n sits at index n-1
  localparam int unsigned POS_MOD = 0;
  localparam int unsigned POS_BYPASS = 7;
  localparam int unsigned POS_SCALE = 12;
  localparam int unsigned POS_REFDIV = 14;
  localparam int unsigned POS_FBDIV = 21;
  localparam int unsigned POS_DOUBLE = 30;
  localparam int unsigned POS_POL = 38;
  localparam int unsigned POS_SUPPRESS = 45;
  localparam int unsigned POS_AUX = 46;
  localparam int unsigned POS_REFEDGE = 55;
  // power-on: divide by four (4a), reference bypass, fixed-one bits 7 and 10
  localparam logic [55:0] CTRL_RESET = 56'h00_0000_0000_02c1;
  localparam logic [8:0] FB_MIN = 9'h025;
  localparam logic [8:0] FB_MAX = 9'h188;
  typedef enum logic [1:0] {
    LPC_SC_DIV1,
    LPC_SC_DIV2,
    LPC_SC_DIV4,
    LPC_SC_TEST
  } lpc_scale_e;

  // pixel divider modulus from the four-bit code
  function automatic logic [4:0] lpc_modulus(input logic [3:0] code);
    logic [4:0] m;
    m = 5'h03;
    if (code[3]) begin
      unique case (code[1:0])
        2'h0: m = 5'h0c;
        2'h1: m = 5'h10;
        2'h2: m = 5'h10;
        2'h3: m = 5'h14;
      endcase
    end else begin
      unique case (code[2:0])
        3'h0: m = 5'h03;
        3'h1: m = 5'h04;
        3'h2: m = 5'h04;
        3'h3: m = 5'h05;
        3'h4: m = 5'h06;
        3'h5: m = 5'h08;
        3'h6: m = 5'h08;
        3'h7: m = 5'h0a;
      endcase
    end
    return m;
  endfunction

  // restart delay in half vco periods (twice the k figure)
  function automatic logic [4:0] lpc_k_half(input logic [3:0] code);
    logic [4:0] k;
    k = 5'h04;
    if (code[3]) begin
      unique case (code[1:0])
        2'h0: k = 5'h0d;
        2'h1: k = 5'h13;
        2'h2: k = 5'h12;
        2'h3: k = 5'h18;
      endcase
    end else begin
      unique case (code[2:0])
        3'h0: k = 5'h04;
        3'h1: k = 5'h07;
        3'h2: k = 5'h06;
        3'h3: k = 5'h09;
        3'h4: k = 5'h07;
        3'h5: k = 5'h0b;
        3'h6: k = 5'h0a;
        3'h7: k = 5'h0e;
      endcase
    end
    return k;
  endfunction
endpackage

// ---- lpc_ps_if.sv ----
// post-scaler settings in, half-period ticks out
// assumes one clock, pclk, on both ends
`timescale 1ns/1ps
interface lpc_ps_if;
  logic bypass;
  logic ref_level;
  logic [1:0] scale;
  logic vco_half;
  logic div_half;
  modport scaler (input bypass, ref_level, scale, output vco_half, div_half);
  modport user (output bypass, ref_level, scale, input vco_half, div_half);
endinterface

// ---- lpc_postscaler.sv ----
// post-scaler: turns the vco (or the bypassed reference) into half ticks
// assumes ref_level is already synchronous to pclk
`timescale 1ns/1ps
module lpc_postscaler (
  input wire logic pclk,
  input wire logic presetn,
  lpc_ps_if.scaler ps
);
  logic ref_q_reg;
  logic [1:0] cnt_reg;
  logic src_half;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q_reg <= 1'b0;
    end else begin
      ref_q_reg <= ps.ref_level;
    end
  end

  // bypass: every reference edge is half a source period
  assign src_half = ps.bypass ? (ps.ref_level ^ ref_q_reg) : 1'b1;
  assign ps.vco_half = src_half;

  // free running
  // never cleared by the gate input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
    end else if (src_half) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  always_comb begin
    unique case (lpc_pkg::lpc_scale_e'(ps.scale))
      lpc_pkg::LPC_SC_DIV1: ps.div_half = src_half;
      lpc_pkg::LPC_SC_DIV2: ps.div_half = src_half & cnt_reg[0];
      lpc_pkg::LPC_SC_DIV4: ps.div_half = src_half & (&cnt_reg);
      lpc_pkg::LPC_SC_TEST: ps.div_half = src_half;
    endcase
  end
endmodule

// ---- lpc_pixel_clock_gen_sva.sv ----
// port-level checks for the pixel clock generator
// assumes one clock, pclk, and presetn active low
`timescale 1ns/1ps
module lpc_pixel_clock_gen_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_hold_in,
  input wire logic ref_osc_in,
  input wire logic pixel_gate_in,
  input wire logic pixel_clk_out,
  input wire logic ref_div_out,
  input wire logic fb_div_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {lpc_pkg::ADDR_CTRL_LO, lpc_pkg::ADDR_CTRL_HI,
    lpc_pkg::ADDR_STATUS, lpc_pkg::ADDR_SHIFT_LO, lpc_pkg::ADDR_SHIFT_HI};
  ////////////////////////////////////////////////////////////////////////////
  a_apb_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_pready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_unmapped_error: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_no_error: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_error_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read returned data");
  a_idle_after_reset: assert property ($rose(presetn) |-> pixel_clk_out)
    else $error("pixel clock not idle high after reset");
  a_pixel_low_min: assert property ($fell(pixel_clk_out) |-> !pixel_clk_out [*3])
    else $error("pixel low phase shorter than three");
  a_pixel_high_min: assert property ($rose(pixel_clk_out) |-> pixel_clk_out [*3])
    else $error("pixel high phase shorter than three");
  a_fb_pulse_gap: assert property ($rose(fb_div_out) |=> !fb_div_out [*8])
    else $error("feedback divider pulses too close");
  a_ref_pulse_one: assert property (ref_div_out |=> !ref_div_out)
    else $error("reference divider pulse too long");
endmodule
bind lpc_pixel_clock_gen lpc_pixel_clock_gen_sva chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
  .serial_hold_in(serial_hold_in), .ref_osc_in(ref_osc_in),
  .pixel_gate_in(pixel_gate_in), .pixel_clk_out(pixel_clk_out),
  .ref_div_out(ref_div_out), .fb_div_out(fb_div_out));

// ---- lpc_host_model.sv ----
// host and beam-detect side: serial programming, gate, reference oscillator
// assumes callers enter tasks just after a pclk rising edge
`timescale 1ns/1ps
module lpc_host_model (
  input wire logic pclk,
  output logic serial_shift_clock,
  output logic serial_data_in,
  output logic serial_hold_in,
  output logic ref_osc_in,
  output logic pixel_gate_in
);
  logic [1:0] cnt = 2'h0;
  initial begin
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
    serial_hold_in = 1'b0;
    ref_osc_in = 1'b0;
    pixel_gate_in = 1'b1;
  end
  // free-running reference, slow enough for single-cycle divider pulses
  always @(posedge pclk) begin
    cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    if (cnt == 2'h2) ref_osc_in <= ~ref_osc_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  // bit one first, hold with last
  task automatic send(input logic [55:0] w, input logic hl);
    for (int i = 0; i < 56; i++) begin
      @(posedge pclk);
      serial_shift_clock <= 1'b0;
      serial_data_in <= w[i];
      serial_hold_in <= hl && (i == 55);
      @(posedge pclk);
      serial_shift_clock <= 1'b1;
    end
    @(posedge pclk);
    // clock parks low, data shows no stale bit
    serial_shift_clock <= 1'b0;
    serial_data_in <= ~serial_data_in;
    serial_hold_in <= 1'b0;
  endtask
  // callers keep gate off a full pixel period
  task automatic gate(input logic lvl);
    pixel_gate_in <= lvl;
  endtask
endmodule

// ---- laser_pixel_clock_gen_test.sv ----
// bench for the pixel clock generator: apb, serial load, pixel timing
// assumes lpc_host_model stands on the serial and gate pins
`timescale 1ns/1ps
module laser_pixel_clock_gen_test;
  localparam logic [55:0] W = 56'ha5_1234_b2c3_d4e1;
  // reference modulus 4, feedback modulus 300
  localparam logic [31:0] DIVS = (32'h3 << lpc_pkg::POS_REFDIV) |
    (32'h12c << lpc_pkg::POS_FBDIV);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, sck, sdi, shold, refo, gate, pix, refd, fbd;
  int miscompares = 0;
  int num_checks = 0;
  int n, lo, hi;
  int mods [13] = '{3, 4, 4, 5, 6, 8, 8, 10, 12, 16, 16, 20, 12};
  int kh [13] = '{4, 7, 6, 9, 7, 11, 10, 14, 13, 19, 18, 24, 13};
  initial forever #4 pclk = ~pclk;
  lpc_pixel_clock_gen uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_shift_clock(sck),
    .serial_data_in(sdi), .serial_hold_in(shold), .ref_osc_in(refo),
    .pixel_gate_in(gate), .pixel_clk_out(pix), .ref_div_out(refd), .fb_div_out(fbd));
  lpc_host_model host (.pclk(pclk), .serial_shift_clock(sck), .serial_data_in(sdi),
    .serial_hold_in(shold), .ref_osc_in(refo), .pixel_gate_in(gate));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_len(input logic lvl, output int c);
    c = 0;
    while (pix === lvl && c < 400) begin
      @(posedge pclk);
      c++;
    end
    if (c == 400) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic hold_chk(input logic lvl);
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      n += (pix !== lvl);
    end
    check("steady", n, 0);
  endtask
  task automatic pulse_gap(input logic fb, output int g);
    int c;
    c = 0;
    while ((fb ? fbd : refd) !== 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while ((fb ? fbd : refd) !== 1'b1 && g < 2000);
    if (c == 2000 || g == 2000) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic setup(input logic [31:0] l, input logic [31:0] h, input logic pol);
    apb(1'b1, lpc_pkg::ADDR_CTRL_LO, l);
    apb(1'b1, lpc_pkg::ADDR_CTRL_HI, h);
    host.gate(!pol);
    repeat (200) @(posedge pclk);
  endtask
  task automatic pix_run(input logic [3:0] c, input logic [1:0] sc, input logic pol,
                         input int m, input int k);
    int t;
    t = m << sc;
    setup(32'h240 | 32'(c) | (32'(sc) << 12), 32'(pol) << 6, pol);
    host.gate(pol);
    run_len(1'b1, n);
    if (sc == 2'h0) check("delay", n >= k + 1 && n <= k + 4, 1);
    run_len(1'b0, lo); check("low", lo, t);
    run_len(1'b1, hi); check("high", hi, t);
    host.gate(!pol);
    run_len(1'b0, lo); check("finish", lo, t);
    hold_chk(1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("idle", {31'h0, pix}, 32'h1);
    apb(1'b0, lpc_pkg::ADDR_CTRL_LO, 32'h0);
    check("ctrl_lo", r, lpc_pkg::CTRL_RESET[31:0]);
    check("bypass", {31'h0, r[lpc_pkg::POS_BYPASS]}, 32'h1);
    apb(1'b0, lpc_pkg::ADDR_CTRL_HI, 32'h0);
    check("ctrl_hi", r, {8'h0, lpc_pkg::CTRL_RESET[55:32]});
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {r[30:0], e}, 32'h1);
    host.send(W, 1'b0);
    apb(1'b0, lpc_pkg::ADDR_SHIFT_LO, 32'h0);
    check("shift_lo", r, W[31:0]);
    apb(1'b0, lpc_pkg::ADDR_SHIFT_HI, 32'h0);
    check("shift_hi", r, {8'h0, W[55:32]});
    apb(1'b0, lpc_pkg::ADDR_CTRL_LO, 32'h0);
    check("kept", r, lpc_pkg::CTRL_RESET[31:0]);
    apb(1'b0, lpc_pkg::ADDR_STATUS, 32'h0);
    check("bits", {26'h0, r[13:8]}, 32'h38);
    host.send(W, 1'b1);
    apb(1'b0, lpc_pkg::ADDR_CTRL_LO, 32'h0);
    check("loaded", r, W[31:0]);
    // polarity alternates so both gate senses restart the divider
    for (int i = 0; i < 13; i++) pix_run(i[3:0], 2'h0, i[0], mods[i], kh[i]);
    pix_run(4'h0, 2'h1, 1'b0, 3, 0);
    pix_run(4'h0, 2'h2, 1'b1, 3, 0);
    setup(32'h3240, 32'h4000, 1'b0);
    hold_chk(1'b1);
    setup(32'h3240, 32'h0, 1'b0);
    hold_chk(1'b0);
    setup(32'h240, 32'h2000, 1'b0);
    host.gate(1'b0);
    hold_chk(1'b0);
    // let the running divider settle high before suppress is lifted
    host.gate(1'b1);
    repeat (60) @(posedge pclk);
    setup(32'h240 | DIVS, 32'h0, 1'b0);
    // the host reference rises every 6 pclk, a vco period is 2 pclk
    pulse_gap(1'b0, n); check("ref_gap", n, 24);
    pulse_gap(1'b1, n); check("fb_gap", n, 600);
    setup(32'h240 | DIVS | (32'h1 << lpc_pkg::POS_DOUBLE), 32'h0, 1'b0);
    pulse_gap(1'b1, n); check("fb_double", n, 1200);
    complete_run();
  end
endmodule
